// File: design/gfc_irq_regs.sv
// Purpose: sticky event status, enable mask and level interrupt
// Assumes: clear and enable writes are one-cycle strobes
// Notes:   an event in the cycle of its clear keeps the bit set
`timescale 1ns/10ps
module gfc_irq_regs (
    input  wire logic                      mclk_i,
    input  wire logic                      arst_n_i,
    input  wire logic [gfc_pkg::IRQ_W-1:0] set_i,
    input  wire logic                      clr_wr_i,
    input  wire logic                      en_wr_i,
    input  wire logic [gfc_pkg::IRQ_W-1:0] wdata_i,
    output logic      [gfc_pkg::IRQ_W-1:0] status_o,
    output logic      [gfc_pkg::IRQ_W-1:0] enable_o,
    output logic                           irq_o
);

    typedef struct packed {
        logic [gfc_pkg::IRQ_W-1:0] stat;
        logic [gfc_pkg::IRQ_W-1:0] en;
    } gfc_irq_st_t;

    gfc_irq_st_t s_q;
    gfc_irq_st_t s_d;

    always_comb begin
        s_d = s_q;
        if (clr_wr_i) begin
            s_d.stat = s_q.stat & ~wdata_i;
        end
        s_d.stat = s_d.stat | set_i;
        if (en_wr_i) begin
            s_d.en = wdata_i;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_q      <= '0;
            s_q.en   <= gfc_pkg::IRQ_EN_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign status_o = s_q.stat;
    assign enable_o = s_q.en;
    assign irq_o    = |(s_q.stat & s_q.en);

    set_wins_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        |set_i |=> (status_o & $past(set_i)) == $past(set_i))
        else $error("event lost against clear");

endmodule : gfc_irq_regs

// File: design/gfc_pin_mux.sv
// Purpose: function routing, pull-up and drive control for general pin one
// Assumes: internal event sources are on mclk_i; only the pin itself is asynchronous
// Notes:   pin output and enable are registered, so they follow a setting one cycle late
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps

// Behaviour
// R1: bits 7:6 of the pin configuration set the pin drive strength.
// R2: the pull-up is on only while its enable bit is set and the pin is a digital input.
// R3: select 00000 drives the pin with the inverted power-on-reset indication.
// R4: the wakeup timer function drives the pin high once the timer has expired.
// R5: the low-battery function drives the pin high while supply is below threshold.
// R6: codes 00100, 00101, 00110 take falling, rising or any edge as an interrupt.
// R7: select 00111 drops all digital use and hands the pin to the converter.
// R8: the receive clock function puts the receive bit clock on the pin.
// R9: select 10001 takes the pin as an input retransmission request from outside.
// R10: two codes drive the pin with the antenna one or antenna two switch control.
// R11: select 11001 drives the pin with the valid preamble indication.
// R12: select 11011 drives the pin with the sync word indication.
// R13: direct output drives the direct-I/O bit; direct input reads the pin back there.
// R14: external interrupt status of this pin reads in bit 5 of the I/O port register.
// R15: reserved and unassigned codes drive the pin low and take no input from it.
module gfc_pin_mux (
    input  wire logic       mclk_i,
    input  wire logic       arst_n_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    input  wire logic       por_i,
    input  wire logic       wakeup_expired_i,
    input  wire logic       batt_low_i,
    input  wire logic       rx_bit_clk_i,
    input  wire logic       rx_data_i,
    input  wire logic       rx_state_i,
    input  wire logic       fifo_almost_full_i,
    input  wire logic       ant_sel_i,
    input  wire logic       preamble_valid_i,
    input  wire logic       preamble_invalid_i,
    input  wire logic       sync_det_i,
    input  wire logic       cca_i,
    input  wire logic       pin_i,
    output logic            pin_o,
    output logic            pin_oe_o,
    output logic            pullup_en_o,
    output logic      [1:0] drive_strength_o,
    output logic            analog_en_o,
    output logic            ext_int_o,
    output logic            retx_req_o,
    output logic            irq_o
);

    typedef struct packed {
        logic [7:0] cfg;
        logic       direct_io_value;
        logic [7:0] rdata;
        logic       pin;
        logic       oe;
        logic       pup;
        logic       ana;
        logic       wake_prev;
        logic       ext_hit;
        logic       retx_hit;
    } gfc_mux_st_t;

    gfc_mux_st_t s_q;
    gfc_mux_st_t s_d;

    logic                      pin_lvl;
    logic                      pin_rise;
    logic                      pin_fall;
    logic [gfc_pkg::IRQ_W-1:0] irq_set;
    logic [gfc_pkg::IRQ_W-1:0] irq_stat;
    logic [gfc_pkg::IRQ_W-1:0] irq_en;
    logic                      clr_wr;
    logic                      en_wr;
    logic                      ext_hit;
    logic                      retx_hit;
    logic                      wake_rise;
    gfc_pkg::gfc_sel_t         sel;

    // codes that read the pin as a digital level
    function automatic logic is_dig_in(input logic [4:0] code);
        case (code)
            gfc_pkg::SEL_DIR_IN,
            gfc_pkg::SEL_INT_FALL,
            gfc_pkg::SEL_INT_RISE,
            gfc_pkg::SEL_INT_ANY,
            gfc_pkg::SEL_RETX_REQ: is_dig_in = 1'b1;
            default:               is_dig_in = 1'b0;
        endcase
    endfunction : is_dig_in

    // codes that make the pin an interrupt source
    function automatic logic is_ext_int(input logic [4:0] code);
        case (code)
            gfc_pkg::SEL_INT_FALL,
            gfc_pkg::SEL_INT_RISE,
            gfc_pkg::SEL_INT_ANY: is_ext_int = 1'b1;
            default:              is_ext_int = 1'b0;
        endcase
    endfunction : is_ext_int

    gfc_pin_sync u_sync (
        .mclk_i   (mclk_i),
        .arst_n_i (arst_n_i),
        .pin_i    (pin_i),
        .level_o  (pin_lvl),
        .rise_o   (pin_rise),
        .fall_o   (pin_fall)
    );

    assign sel = gfc_pkg::gfc_sel_t'(s_q.cfg[gfc_pkg::SEL_MSB:gfc_pkg::SEL_LSB]);

    // edge qualification per interrupt mode
    always_comb begin
        case (sel)
            gfc_pkg::SEL_INT_FALL: ext_hit = pin_fall; // R6
            gfc_pkg::SEL_INT_RISE: ext_hit = pin_rise; // R6
            gfc_pkg::SEL_INT_ANY:  ext_hit = pin_rise | pin_fall; // R6
            default:               ext_hit = 1'b0;
        endcase
    end

    // a request is the pin going active while in retransmission mode
    assign retx_hit  = (sel == gfc_pkg::SEL_RETX_REQ) && pin_rise; // R9
    assign wake_rise = wakeup_expired_i && !s_q.wake_prev;

    assign clr_wr = wr_i && (addr_i == gfc_pkg::ADDR_IRQ_CLR);
    assign en_wr  = wr_i && (addr_i == gfc_pkg::ADDR_IRQ_EN);

    always_comb begin
        irq_set                    = '0;
        irq_set[gfc_pkg::IRQ_EXT]  = ext_hit; // R14
        irq_set[gfc_pkg::IRQ_RETX] = retx_hit;
        irq_set[gfc_pkg::IRQ_WAKE] = wake_rise;
    end

    gfc_irq_regs u_irq (
        .mclk_i   (mclk_i),
        .arst_n_i (arst_n_i),
        .set_i    (irq_set),
        .clr_wr_i (clr_wr),
        .en_wr_i  (en_wr),
        .wdata_i  (wdata_i[gfc_pkg::IRQ_W-1:0]),
        .status_o (irq_stat),
        .enable_o (irq_en),
        .irq_o    (irq_o)
    );

    always_comb begin
        s_d           = s_q;
        s_d.wake_prev = wakeup_expired_i;
        s_d.ext_hit   = ext_hit;
        s_d.retx_hit  = retx_hit;

        // register writes
        if (wr_i) begin
            case (addr_i)
                gfc_pkg::ADDR_PIN_CFG: s_d.cfg = wdata_i;
                gfc_pkg::ADDR_IO_PORT: s_d.direct_io_value = wdata_i[gfc_pkg::DIO_BIT];
                default:               s_d.cfg = s_q.cfg;
            endcase
        end

        // read data stand only in the cycle after the strobe
        s_d.rdata = 8'h00;
        if (rd_i) begin
            case (addr_i)
                gfc_pkg::ADDR_PIN_CFG: s_d.rdata = s_q.cfg;
                gfc_pkg::ADDR_IO_PORT: begin
                    s_d.rdata[gfc_pkg::EXTST_BIT] = irq_stat[gfc_pkg::IRQ_EXT]; // R14
                    s_d.rdata[gfc_pkg::DIO_BIT]   = (sel == gfc_pkg::SEL_DIR_IN) ?
                                                    pin_lvl : s_q.direct_io_value; // R13
                end
                gfc_pkg::ADDR_IRQ_STAT: s_d.rdata[gfc_pkg::IRQ_W-1:0] = irq_stat;
                gfc_pkg::ADDR_IRQ_EN:   s_d.rdata[gfc_pkg::IRQ_W-1:0] = irq_en;
                default:                s_d.rdata = 8'h00;
            endcase
        end

        // pin routing; the settings in force before a write decide this cycle
        s_d.pin = 1'b0;
        s_d.oe  = 1'b1;
        s_d.ana = 1'b0;
        case (sel)
            gfc_pkg::SEL_POR_N:    s_d.pin = !por_i; // R3
            gfc_pkg::SEL_WAKE:     s_d.pin = wakeup_expired_i; // R4
            gfc_pkg::SEL_BATT_LOW: s_d.pin = batt_low_i; // R5
            gfc_pkg::SEL_DIR_IN,
            gfc_pkg::SEL_INT_FALL,
            gfc_pkg::SEL_INT_RISE,
            gfc_pkg::SEL_INT_ANY,
            gfc_pkg::SEL_RETX_REQ: s_d.oe  = 1'b0; // R9
            gfc_pkg::SEL_ADC_IN: begin
                s_d.oe  = 1'b0; // R7
                s_d.ana = 1'b1; // R7
            end
            gfc_pkg::SEL_DIR_OUT:  s_d.pin = s_q.direct_io_value; // R13
            gfc_pkg::SEL_RX_CLK:   s_d.pin = rx_bit_clk_i; // R8
            gfc_pkg::SEL_RX_DATA:  s_d.pin = rx_data_i;
            gfc_pkg::SEL_RX_STATE: s_d.pin = rx_state_i;
            gfc_pkg::SEL_FIFO_AF:  s_d.pin = fifo_almost_full_i;
            gfc_pkg::SEL_ANT1:     s_d.pin = !ant_sel_i; // R10
            gfc_pkg::SEL_ANT2:     s_d.pin = ant_sel_i; // R10
            gfc_pkg::SEL_PRE_OK:   s_d.pin = preamble_valid_i; // R11
            gfc_pkg::SEL_PRE_BAD:  s_d.pin = preamble_invalid_i;
            gfc_pkg::SEL_SYNC_DET: s_d.pin = sync_det_i; // R12
            gfc_pkg::SEL_CCA:      s_d.pin = cca_i;
            gfc_pkg::SEL_VDD:      s_d.pin = 1'b1;
            // reference voltage is analog; digital side holds the pin low
            default:               s_d.pin = 1'b0; // R15
        endcase

        // pull-up only helps a floating digital input
        s_d.pup = s_q.cfg[gfc_pkg::PUP_BIT] && is_dig_in(sel); // R2
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_q                 <= '0;
            s_q.cfg             <= gfc_pkg::PIN_CFG_RST;
            s_q.direct_io_value <= gfc_pkg::DIO_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata_o          = s_q.rdata;
    assign pin_o            = s_q.pin;
    assign pin_oe_o         = s_q.oe;
    assign pullup_en_o      = s_q.pup;
    assign drive_strength_o = s_q.cfg[gfc_pkg::DRV_MSB:gfc_pkg::DRV_LSB]; // R1
    assign analog_en_o      = s_q.ana;
    assign ext_int_o        = s_q.ext_hit;
    assign retx_req_o       = s_q.retx_hit;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------

    sequence cfg_write_s;
        wr_i && addr_i == gfc_pkg::ADDR_PIN_CFG;
    endsequence

    sequence fall_mode_edge_s;
        sel == gfc_pkg::SEL_INT_FALL && pin_fall;
    endsequence

    sequence rise_mode_edge_s;
        sel == gfc_pkg::SEL_INT_RISE && pin_rise;
    endsequence

    drive_follows_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R1
        cfg_write_s |=> drive_strength_o == $past(wdata_i[7:6]))
        else $error("drive strength not taken from write");

    pullup_gate_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R2
        pullup_en_o |-> !pin_oe_o && !analog_en_o)
        else $error("pull-up on a non-input pin");

    por_invert_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R3
        sel == gfc_pkg::SEL_POR_N |=> pin_oe_o && pin_o == !$past(por_i))
        else $error("inverted reset indication wrong");

    wake_high_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R4
        sel == gfc_pkg::SEL_WAKE && wakeup_expired_i |=> pin_o && pin_oe_o)
        else $error("timer expiry not shown");

    batt_low_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R5
        sel == gfc_pkg::SEL_BATT_LOW |=> pin_o == $past(batt_low_i))
        else $error("battery alarm not shown");

    ext_fall_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R6
        fall_mode_edge_s |=> ext_int_o && irq_stat[gfc_pkg::IRQ_EXT])
        else $error("falling edge interrupt missed");

    ext_rise_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R6
        rise_mode_edge_s |=> ext_int_o ##1 irq_stat[gfc_pkg::IRQ_EXT])
        else $error("rising edge interrupt missed");

    ext_quiet_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R6
        !is_ext_int(sel) |=> !ext_int_o)
        else $error("interrupt outside interrupt mode");

    adc_route_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R7
        sel == gfc_pkg::SEL_ADC_IN |=> analog_en_o && !pin_oe_o && !pullup_en_o)
        else $error("analog routing wrong");

    rx_clock_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R8
        sel == gfc_pkg::SEL_RX_CLK |=> pin_o == $past(rx_bit_clk_i))
        else $error("receive clock not on pin");

    retx_take_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R9
        sel == gfc_pkg::SEL_RETX_REQ && pin_rise |=> retx_req_o && !pin_oe_o)
        else $error("retransmission request missed");

    ant_pair_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R10
        sel == gfc_pkg::SEL_ANT2 |=> pin_o == $past(ant_sel_i))
        else $error("antenna switch wrong");

    preamble_out_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R11
        sel == gfc_pkg::SEL_PRE_OK |=> pin_o == $past(preamble_valid_i))
        else $error("preamble indication wrong");

    sync_word_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R12
        sel == gfc_pkg::SEL_SYNC_DET |=> pin_o == $past(sync_det_i))
        else $error("sync indication wrong");

    direct_out_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R13
        sel == gfc_pkg::SEL_DIR_OUT |=> pin_o == $past(s_q.direct_io_value))
        else $error("direct output wrong");

    ext_status_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R14
        rd_i && addr_i == gfc_pkg::ADDR_IO_PORT |=>
        rdata_o[gfc_pkg::EXTST_BIT] == $past(irq_stat[gfc_pkg::IRQ_EXT]))
        else $error("interrupt status not readable");

    reserved_low_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R15
        sel == 5'h10 |=> !pin_o && pin_oe_o && !pullup_en_o)
        else $error("reserved code not low");

    sequence any_mode_edge_s;
        sel == gfc_pkg::SEL_INT_ANY && (pin_rise || pin_fall);
    endsequence

    ext_any_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R6
        any_mode_edge_s |=> ext_int_o && irq_stat[gfc_pkg::IRQ_EXT])
        else $error("state change interrupt missed");

    ant_one_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R10
        sel == gfc_pkg::SEL_ANT1 |=> pin_o == !$past(ant_sel_i))
        else $error("antenna one switch wrong");

    input_release_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R9
        is_dig_in(sel) |=> !pin_oe_o && !analog_en_o)
        else $error("input pin still driven");

    rdata_idle_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        !rd_i |=> rdata_o == 8'h00)
        else $error("read data outside read cycle");

endmodule : gfc_pin_mux

// File: design/gfc_pin_sync.sv
// Purpose: brings the pin level into the clock domain and reports its edges
// Assumes: pin may change at any time
// Notes:   level moves only once the second and third stages agree
`timescale 1ns/10ps
module gfc_pin_sync (
    input  wire logic mclk_i,
    input  wire logic arst_n_i,
    input  wire logic pin_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
        logic rise;
        logic fall;
    } gfc_sync_st_t;

    gfc_sync_st_t s_q;
    gfc_sync_st_t s_d;

    always_comb begin
        s_d      = s_q;
        s_d.s1   = pin_i;
        s_d.s2   = s_q.s1;
        s_d.s3   = s_q.s2;
        s_d.rise = 1'b0;
        s_d.fall = 1'b0;
        // s1 feeds only s2; the agree test looks at the later stages
        if (s_q.s2 == s_q.s3 && s_q.s3 != s_q.lvl) begin
            s_d.lvl  = s_q.s3;
            s_d.rise = s_q.s3;
            s_d.fall = !s_q.s3;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign level_o = s_q.lvl;
    assign rise_o  = s_q.rise;
    assign fall_o  = s_q.fall;

    edge_once_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        !(rise_o && fall_o)) else $error("rise and fall together");

endmodule : gfc_pin_sync

// File: design/gfc_pkg.sv
// Purpose: shared constants and types for the pin-one function configuration block
// Assumes: 8-bit register port, one 100 MHz clock
// Notes:   function codes follow the layout shared with the neighbouring pins
package gfc_pkg;

    // register map (byte addresses on the plain register port)
    localparam logic [7:0] ADDR_PIN_CFG  = 8'h0C;
    localparam logic [7:0] ADDR_IO_PORT  = 8'h0E;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h40;
    localparam logic [7:0] ADDR_IRQ_CLR  = 8'h41;
    localparam logic [7:0] ADDR_IRQ_EN   = 8'h42;

    // pin configuration fields
    localparam int DRV_MSB = 7;
    localparam int DRV_LSB = 6;
    localparam int PUP_BIT = 5;
    localparam int SEL_MSB = 4;
    localparam int SEL_LSB = 0;

    // i/o port configuration fields
    localparam int DIO_BIT   = 1;
    localparam int EXTST_BIT = 5;

    // interrupt status layout
    localparam int IRQ_W    = 3;
    localparam int IRQ_EXT  = 0;
    localparam int IRQ_RETX = 1;
    localparam int IRQ_WAKE = 2;

    // values after reset
    localparam logic [7:0]       PIN_CFG_RST = 8'h00;
    localparam logic             DIO_RST     = 1'b0;
    localparam logic [IRQ_W-1:0] IRQ_EN_RST  = 3'h0;

    typedef enum logic [4:0] {
        SEL_POR_N     = 5'h00,
        SEL_WAKE      = 5'h01,
        SEL_BATT_LOW  = 5'h02,
        SEL_DIR_IN    = 5'h03,
        SEL_INT_FALL  = 5'h04,
        SEL_INT_RISE  = 5'h05,
        SEL_INT_ANY   = 5'h06,
        SEL_ADC_IN    = 5'h07,
        SEL_DIR_OUT   = 5'h0A,
        SEL_VREF      = 5'h0E,
        SEL_RX_CLK    = 5'h0F,
        SEL_RETX_REQ  = 5'h11,
        SEL_RX_DATA   = 5'h14,
        SEL_RX_STATE  = 5'h15,
        SEL_FIFO_AF   = 5'h16,
        SEL_ANT1      = 5'h17,
        SEL_ANT2      = 5'h18,
        SEL_PRE_OK    = 5'h19,
        SEL_PRE_BAD   = 5'h1A,
        SEL_SYNC_DET  = 5'h1B,
        SEL_CCA       = 5'h1C,
        SEL_VDD       = 5'h1D
    } gfc_sel_t;

endpackage : gfc_pkg

// File: dv/gfc_pin_mux_tb.sv
// Purpose: self-checking bench for the pin-one function block
// Assumes: register port with one-cycle read latency, sources on mclk_i
// Notes:   after the blocking setup at time zero, inputs change by non-blocking assignment just after a rising edge
`timescale 1ns/10ps
module gfc_pin_mux_tb;
    logic        mclk_i, arst_n_i, wr_i, rd_i, pin_i, pin_o, pin_oe_o, pullup_en_o;
    logic        analog_en_o, ext_int_o, retx_req_o, irq_o, ext_oe, ext_val;
    logic [7:0]  addr_i, wdata_i, rdata_o;
    logic [1:0]  drive_strength_o;
    logic [11:0] src;
    int          failures, compares;

    gfc_pin_mux i_dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .por_i(src[0]),
        .wakeup_expired_i(src[1]), .batt_low_i(src[2]), .rx_bit_clk_i(src[3]),
        .rx_data_i(src[4]), .rx_state_i(src[5]), .fifo_almost_full_i(src[6]),
        .ant_sel_i(src[7]), .preamble_valid_i(src[8]), .preamble_invalid_i(src[9]),
        .sync_det_i(src[10]), .cca_i(src[11]), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe_o(pin_oe_o), .pullup_en_o(pullup_en_o), .drive_strength_o(drive_strength_o),
        .analog_en_o(analog_en_o), .ext_int_o(ext_int_o), .retx_req_o(retx_req_o),
        .irq_o(irq_o));

    gfc_pin_partner i_partner (.mclk_i(mclk_i), .dev_val_i(pin_o), .dev_oe_i(pin_oe_o),
        .pullup_i(pullup_en_o), .ext_oe_i(ext_oe), .ext_val_i(ext_val), .level_o(pin_i));

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    task automatic finish_test();
        if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask : rd

    // expected drive value of the pin for a select code with every source at v
    function automatic logic exp_pin(input logic [4:0] s, input logic v);
        case (s)
            5'h00: exp_pin = ~v;
            5'h01, 5'h02: exp_pin = v;
            5'h0A: exp_pin = v;
            5'h0F: exp_pin = v;
            5'h17: exp_pin = ~v;
            5'h18: exp_pin = v;
            5'h19, 5'h1B: exp_pin = v;
            5'h14, 5'h15, 5'h16, 5'h1A, 5'h1C: exp_pin = v;
            5'h1D: exp_pin = 1'b1;
            default: exp_pin = 1'b0;
        endcase
    endfunction : exp_pin

    task automatic t_functions();
        logic [4:0] s;
        logic [7:0] c;
        logic [7:0] d;
        logic       inp;
        logic       drv;
        for (int i = 0; i < 32; i++) begin
            s = i[4:0];
            c = {s[1:0], s[0], s};
            inp = s inside {5'h03, 5'h04, 5'h05, 5'h06, 5'h11};
            drv = !inp && s != 5'h07;
            wr(gfc_pkg::ADDR_PIN_CFG, c);
            rd(gfc_pkg::ADDR_PIN_CFG, d);
            chk(d, c, "config readback");
            for (int v = 0; v < 2; v++) begin
                wr(gfc_pkg::ADDR_IO_PORT, {6'h00, v[0], 1'b0});
                @(posedge mclk_i);
                src <= {12{v[0]}};
                repeat (2) @(posedge mclk_i);
                #1;
                chk(8'(pin_oe_o), 8'(drv), "pin enable");
                if (drv) chk(8'(pin_o), 8'(exp_pin(s, v[0])), "pin value");
                chk(8'(pullup_en_o), 8'(inp && c[5]), "pull-up");
                chk(8'(analog_en_o), 8'(s == 5'h07), "analog route");
                chk(8'(drive_strength_o), 8'(c[7:6]), "drive strength");
            end
        end
    endtask : t_functions

    task automatic t_direct_in();
        logic [7:0] d;
        @(posedge mclk_i);
        ext_oe <= 1'b0;
        wr(gfc_pkg::ADDR_PIN_CFG, 8'h23);
        repeat (6) @(posedge mclk_i);
        rd(gfc_pkg::ADDR_IO_PORT, d);
        chk(d & 8'h02, 8'h02, "pulled-up pin read");
        @(posedge mclk_i);
        ext_oe <= 1'b1;
        ext_val <= 1'b0;
        repeat (6) @(posedge mclk_i);
        rd(gfc_pkg::ADDR_IO_PORT, d);
        chk(d & 8'h02, 8'h00, "low pin read");
    endtask : t_direct_in

    task automatic watch(output int ce, output int cr);
        ce = 0;
        cr = 0;
        repeat (12) begin
            @(posedge mclk_i);
            #1;
            if (ext_int_o === 1'b1) ce++;
            if (retx_req_o === 1'b1) cr++;
        end
    endtask : watch

    task automatic t_edge(input logic [4:0] s, input int nr, input int nf, input bit rx);
        int         ce, cr;
        logic [7:0] d, bits;
        bits = (nr + nf > 0) ? (rx ? 8'h02 : 8'h01) : 8'h00;
        @(posedge mclk_i);
        ext_oe <= 1'b1;
        ext_val <= 1'b0;
        wr(gfc_pkg::ADDR_PIN_CFG, {3'b000, s});
        repeat (8) @(posedge mclk_i);
        wr(gfc_pkg::ADDR_IRQ_CLR, 8'h07);
        wr(gfc_pkg::ADDR_IRQ_EN, rx ? 8'h02 : 8'h01);
        @(posedge mclk_i);
        ext_val <= 1'b1;
        watch(ce, cr);
        chk(8'(rx ? cr : ce), 8'(nr), "pulses on rise");
        chk(8'(rx ? ce : cr), 8'h00, "other pulse on rise");
        @(posedge mclk_i);
        ext_val <= 1'b0;
        watch(ce, cr);
        chk(8'(rx ? cr : ce), 8'(nf), "pulses on fall");
        rd(gfc_pkg::ADDR_IRQ_STAT, d);
        chk(d, bits, "event status");
        chk(8'(irq_o), 8'(bits != 8'h00), "interrupt level");
        rd(gfc_pkg::ADDR_IO_PORT, d);
        chk(d & 8'h20, (bits[0] ? 8'h20 : 8'h00), "port status bit");
        wr(gfc_pkg::ADDR_IRQ_EN, 8'h00);
        @(posedge mclk_i);
        #1;
        chk(8'(irq_o), 8'h00, "masked interrupt");
        wr(gfc_pkg::ADDR_IRQ_CLR, 8'h07);
        rd(gfc_pkg::ADDR_IRQ_STAT, d);
        chk(d, 8'h00, "status after clear");
    endtask : t_edge

    task automatic t_wake();
        logic [7:0] d;
        @(posedge mclk_i);
        src <= 12'h000;
        repeat (2) @(posedge mclk_i);
        wr(gfc_pkg::ADDR_IRQ_CLR, 8'h07);
        wr(gfc_pkg::ADDR_IRQ_EN, 8'h04);
        @(posedge mclk_i);
        src[1] <= 1'b1;
        repeat (3) @(posedge mclk_i);
        rd(gfc_pkg::ADDR_IRQ_STAT, d);
        chk(d, 8'h04, "wakeup status");
        chk(8'(irq_o), 8'h01, "wakeup interrupt");
        wr(gfc_pkg::ADDR_IRQ_CLR, 8'h04);
        @(posedge mclk_i);
        #1;
        chk(8'(irq_o), 8'h00, "interrupt after clear");
    endtask : t_wake

    initial begin
        repeat (50000) @(posedge mclk_i);
        failures++;
        finish_test();
    end

    initial begin
        logic [7:0] d;
        {wr_i, rd_i, ext_oe, ext_val, arst_n_i} = 5'h00;
        addr_i = 8'h00;
        wdata_i = 8'h00;
        src = 12'h000;
        failures = 0;
        compares = 0;
        repeat (20) @(posedge mclk_i);
        #1;
        chk(8'(pin_oe_o), 8'h00, "enable in reset");
        @(posedge mclk_i);
        arst_n_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        #1;
        chk(8'({pin_oe_o, pin_o}), 8'h03, "inverted reset indication");
        rd(gfc_pkg::ADDR_PIN_CFG, d);
        chk(d, gfc_pkg::PIN_CFG_RST, "config after reset");
        rd(8'h55, d);
        chk(d, 8'h00, "unmapped read");
        rd(gfc_pkg::ADDR_IRQ_CLR, d);
        chk(d, 8'h00, "clear register read");
        t_functions();
        t_direct_in();
        t_edge(5'h04, 0, 1, 1'b0);
        t_edge(5'h05, 1, 0, 1'b0);
        t_edge(5'h06, 1, 1, 1'b0);
        t_edge(5'h11, 1, 0, 1'b1);
        t_edge(5'h03, 0, 0, 1'b0);
        t_wake();
        finish_test();
    end
endmodule : gfc_pin_mux_tb

// File: dv/gfc_pin_partner.sv
// Purpose: board-side model of whatever is wired to general pin one
// Assumes: testbench says when the outside party drives and with what value
// Notes:   an undriven pin without pull-up never keeps its last level
`timescale 1ns/10ps
module gfc_pin_partner (
    input  wire logic mclk_i,
    input  wire logic dev_val_i,
    input  wire logic dev_oe_i,
    input  wire logic pullup_i,
    input  wire logic ext_oe_i,
    input  wire logic ext_val_i,
    output logic      level_o
);
    logic last_q = 1'b0;

    always @(posedge mclk_i) begin
        last_q <= level_o;
    end

    always_comb begin
        if (dev_oe_i && ext_oe_i) begin
            level_o = 1'bx;
        end else if (dev_oe_i) begin
            level_o = dev_val_i;
        end else if (ext_oe_i) begin
            level_o = ext_val_i;
        end else if (pullup_i) begin
            level_o = 1'b1;
        end else begin
            // floating: a changing level so no stale value can pass a check
            level_o = ~last_q;
        end
    end
endmodule : gfc_pin_partner
